// ==== bw_monitor_pkg.sv ====
// Offsets, field positions, codes and reset values for the bandwidth monitor control block
package bw_monitor_pkg;
    // ****************************************
    // Feature page offsets
    // ****************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_INSTANCE_SELECT = 12'h800;
    localparam logic [11:0] OFF_CACHE_USAGE_FILTER = 12'h810;
    localparam logic [11:0] OFF_BANDWIDTH_FILTER = 12'h820;
    localparam logic [11:0] OFF_BANDWIDTH_CONTROL = 12'h828;
    localparam logic [11:0] OFF_BANDWIDTH_COUNTER = 12'h830;
    localparam logic [11:0] OFF_BANDWIDTH_CAPTURE = 12'h838;
    localparam logic [11:0] OFF_SOFTWARE_CAPTURE = 12'h840;
    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CTL_ENABLE = 31;
    localparam int CTL_CAPT_SEL_LO = 28;
    localparam int CTL_CLEAR_AFTER = 27;
    localparam int CTL_OVERFLOW = 26;
    localparam int CTL_IRQ_ENABLE = 25;
    localparam int CTL_HOLD = 24;
    localparam int CTL_SHIFT_ENABLE = 19;
    localparam int CTL_GROUP_MATCH = 17;
    localparam int CTL_PARTITION_MATCH = 16;
    localparam logic [7:0] MONITOR_TYPE_BANDWIDTH = 8'h42;
    // ****************************************
    // Filter fields and widths
    // ****************************************
    localparam int FLT_GROUP_LO = 16;
    localparam int GROUP_W = 8;
    localparam int PARTITION_W = 16;
    localparam int INDEX_W = 16;
    localparam int EXT_EVENTS = 6;
    // ****************************************
    // Capture source codes
    // ****************************************
    localparam logic [2:0] CAPT_NONE = 3'h0;
    localparam logic [2:0] CAPT_SOFTWARE = 3'h7;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// ==== label_match.sv ====
// Partition and group label filter for one monitor instance
`timescale 1ns/10ps
module label_match
    import bw_monitor_pkg::*;
(
    // Match enables
    input wire logic group_filter_enable,
    input wire logic partition_filter_enable,
    // Filter values
    input wire logic [bw_monitor_pkg::GROUP_W-1:0] filter_group,
    input wire logic [bw_monitor_pkg::PARTITION_W-1:0] filter_partition,
    // Transfer labels
    input wire logic [bw_monitor_pkg::GROUP_W-1:0] perf_group_label,
    input wire logic [bw_monitor_pkg::PARTITION_W-1:0] partition_label,
    // Result
    output logic hit
);
    always_comb
    begin
        hit = (!group_filter_enable || (perf_group_label == filter_group)) &&
              (!partition_filter_enable || (partition_label == filter_partition));
    end
endmodule

// ==== bw_counter.sv ====
// Byte counter with capture copy, clear on capture and wrap or hold on overflow
`timescale 1ns/10ps
module bw_counter #(
    parameter int COUNT_W = 32,
    parameter int INC_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Counting
    input wire logic count_en,
    input wire logic [INC_W-1:0] increment,
    input wire logic frozen,
    // Capture
    input wire logic capture,
    input wire logic clear_after_capture,
    // Results
    output logic [COUNT_W-1:0] count,
    output logic [COUNT_W-1:0] capture_copy,
    output logic overflow_pulse
);
    logic [COUNT_W:0] sum;

    initial
    begin
        if (INC_W > COUNT_W || COUNT_W < 2)
            $error("bw_counter: increment wider than counter");
    end

    always_comb
    begin
        sum = {1'b0, count} + {{(COUNT_W + 1 - INC_W){1'b0}}, increment};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            capture_copy <= '0;
        else if (capture)
            capture_copy <= count;
    end

    // Capture with clear drops the beat in flight, so the copy is exact
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count <= '0;
            overflow_pulse <= 1'b0;
        end
        else
        begin
            overflow_pulse <= 1'b0;
            if (capture && clear_after_capture)
                count <= '0;
            else if (count_en && !frozen)
            begin
                count <= sum[COUNT_W-1:0];
                overflow_pulse <= sum[COUNT_W];
            end
        end
    end
endmodule

// ==== bandwidth_monitor_control.sv ====
// Banked control registers and instances of the bandwidth usage monitors
`timescale 1ns/10ps
module bandwidth_monitor_control
    import bw_monitor_pkg::*;
#(
    parameter int NUM_MON = 2,
    parameter int COUNT_W = 32,
    parameter int INC_W = 8,
    parameter int SCALE = 4,
    parameter bit HAS_MONITORING = 1'b1,
    parameter bit HAS_BANDWIDTH_MON = 1'b1,
    parameter bit HAS_CAPTURE = 1'b1,
    parameter bit HAS_OVERFLOW = 1'b1,
    parameter bit HAS_IRQ = 1'b1,
    parameter logic [5:0] EXT_EVENTS_BUILT = 6'h01
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Feature page access
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic acc_nonsecure,
    input wire logic [bw_monitor_pkg::ADDR_W-1:0] acc_addr,
    input wire logic [31:0] acc_wdata,
    output logic [31:0] acc_rdata,
    output logic acc_ack,
    // Monitored transfers
    input wire logic xfer_valid,
    input wire logic xfer_nonsecure,
    input wire logic [bw_monitor_pkg::PARTITION_W-1:0] partition_label,
    input wire logic [bw_monitor_pkg::GROUP_W-1:0] perf_group_label,
    input wire logic [INC_W-1:0] xfer_bytes,
    // External capture events 1 to 6
    input wire logic [bw_monitor_pkg::EXT_EVENTS-1:0] ext_capture,
    // Overflow interrupt
    output logic overflow_irq
);
    localparam int N = 2 * NUM_MON;

    // ****************************************
    // Storage, one slot per state and instance
    // ****************************************
    logic [INDEX_W-1:0] sel_reg [2];
    logic [N-1:0] enable_reg;
    logic [2:0] capture_source_select [N];
    logic [N-1:0] clear_after_capture;
    logic [N-1:0] overflow_flag;
    logic [N-1:0] overflow_irq_enable;
    logic [N-1:0] overflow_hold;
    logic [N-1:0] value_shift_enable;
    logic [N-1:0] group_filter_enable;
    logic [N-1:0] partition_filter_enable;
    logic [GROUP_W-1:0] bw_group [N];
    logic [PARTITION_W-1:0] bw_partition [N];
    logic [31:0] cache_usage_filter [N];
    logic [COUNT_W-1:0] count [N];
    logic [COUNT_W-1:0] capture_copy [N];
    logic [N-1:0] overflow_pulse;
    logic [N-1:0] capture;
    logic [N-1:0] hit;
    logic [1:0] sw_capture;

    // ****************************************
    // Access decode
    // ****************************************
    logic bank;
    logic in_range;
    logic [$clog2(N)-1:0] slot;
    logic write_ok;
    logic ctl_present;

    initial
    begin
        if (NUM_MON < 1 || NUM_MON > 65536 || SCALE < 0 || SCALE >= COUNT_W || COUNT_W > 32)
            $error("bandwidth_monitor_control: unsupported parameters");
    end

    always_comb
    begin
        bank = acc_nonsecure;
        in_range = (sel_reg[bank] < NUM_MON);
        slot = in_range ? ($clog2(N))'({bank, sel_reg[bank]} - {bank, 16'h0}
                                       + (bank ? NUM_MON : 0)) : '0;
        write_ok = acc_req && acc_write;
        ctl_present = HAS_MONITORING && HAS_BANDWIDTH_MON;
    end

    always_comb
    begin
        sw_capture = 2'b00;
        if (write_ok && acc_addr == OFF_SOFTWARE_CAPTURE)
            sw_capture[bank] = 1'b1;
    end

    // Selector, one copy per security state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_reg[0] <= '0;
            sel_reg[1] <= '0;
        end
        else if (write_ok && acc_addr == OFF_INSTANCE_SELECT)
            sel_reg[bank] <= acc_wdata[INDEX_W-1:0];
    end

    // ****************************************
    // Per-slot logic
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : slot_gen
            localparam bit SLOT_NS = (g >= NUM_MON);
            logic sel_here;
            logic ctl_wr;
            logic ext_hit;

            always_comb
            begin
                sel_here = in_range && (slot == ($clog2(N))'(g)) && (bank == SLOT_NS);
                ctl_wr = write_ok && sel_here && ctl_present
                         && acc_addr == OFF_BANDWIDTH_CONTROL;
                ext_hit = 1'b0;
                if (capture_source_select[g] != CAPT_NONE && capture_source_select[g] != CAPT_SOFTWARE)
                    ext_hit = EXT_EVENTS_BUILT[capture_source_select[g] - 3'h1]
                              && ext_capture[capture_source_select[g] - 3'h1];
                capture[g] = HAS_CAPTURE && (ext_hit
                    || (capture_source_select[g] == CAPT_SOFTWARE && sw_capture[SLOT_NS]));
            end

            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    enable_reg[g] <= 1'b0;
                    capture_source_select[g] <= CAPT_NONE;
                    clear_after_capture[g] <= 1'b0;
                    overflow_irq_enable[g] <= 1'b0;
                    overflow_hold[g] <= 1'b0;
                    value_shift_enable[g] <= 1'b0;
                    group_filter_enable[g] <= 1'b0;
                    partition_filter_enable[g] <= 1'b0;
                end
                else if (ctl_wr)
                begin
                    enable_reg[g] <= acc_wdata[CTL_ENABLE];
                    capture_source_select[g] <= HAS_CAPTURE ?
                        acc_wdata[CTL_CAPT_SEL_LO+:3] : CAPT_NONE;
                    clear_after_capture[g] <= HAS_CAPTURE && acc_wdata[CTL_CLEAR_AFTER];
                    overflow_irq_enable[g] <= HAS_IRQ && acc_wdata[CTL_IRQ_ENABLE];
                    overflow_hold[g] <= HAS_OVERFLOW && acc_wdata[CTL_HOLD];
                    value_shift_enable[g] <= acc_wdata[CTL_SHIFT_ENABLE];
                    group_filter_enable[g] <= acc_wdata[CTL_GROUP_MATCH];
                    partition_filter_enable[g] <= acc_wdata[CTL_PARTITION_MATCH];
                end
            end

            // A fresh overflow beats a software clear in the same cycle
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    overflow_flag[g] <= 1'b0;
                else if (HAS_OVERFLOW)
                    overflow_flag[g] <= (ctl_wr ? acc_wdata[CTL_OVERFLOW] : overflow_flag[g])
                                        | overflow_pulse[g];
            end

            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    bw_group[g] <= '0;
                    bw_partition[g] <= '0;
                    cache_usage_filter[g] <= RESET_WORD;
                end
                else if (write_ok && sel_here)
                begin
                    if (acc_addr == OFF_BANDWIDTH_FILTER)
                    begin
                        bw_group[g] <= acc_wdata[FLT_GROUP_LO+:GROUP_W];
                        bw_partition[g] <= acc_wdata[PARTITION_W-1:0];
                    end
                    if (acc_addr == OFF_CACHE_USAGE_FILTER)
                        cache_usage_filter[g] <= {8'h00, acc_wdata[23:0]};
                end
            end

            label_match u_match (
                .group_filter_enable(group_filter_enable[g]),
                .partition_filter_enable(partition_filter_enable[g]),
                .filter_group(bw_group[g]),
                .filter_partition(bw_partition[g]),
                .perf_group_label(perf_group_label),
                .partition_label(partition_label),
                .hit(hit[g])
            );

            bw_counter #(
                .COUNT_W(COUNT_W),
                .INC_W(INC_W)
            ) u_counter (
                .clk(clk),
                .rst(rst),
                .count_en(enable_reg[g] && xfer_valid && xfer_nonsecure == SLOT_NS && hit[g]),
                .increment(xfer_bytes),
                .frozen(overflow_hold[g] && overflow_flag[g]),
                .capture(capture[g]),
                .clear_after_capture(clear_after_capture[g]),
                .count(count[g]),
                .capture_copy(capture_copy[g]),
                .overflow_pulse(overflow_pulse[g])
            );
        end
    endgenerate

    // ****************************************
    // Read data
    // ****************************************
    logic [31:0] read_word;
    logic [COUNT_W-1:0] scaled;
    logic [COUNT_W-1:0] scaled_copy;

    always_comb
    begin
        scaled = value_shift_enable[slot] ? (count[slot] >> SCALE) : count[slot];
        scaled_copy = value_shift_enable[slot] ? (capture_copy[slot] >> SCALE) : capture_copy[slot];
        read_word = 32'h0000_0000;
        case (acc_addr)
            OFF_INSTANCE_SELECT: read_word = {16'h0000, sel_reg[bank]};
            OFF_CACHE_USAGE_FILTER: read_word = in_range ? cache_usage_filter[slot] : 32'h0;
            OFF_BANDWIDTH_FILTER:
                if (in_range)
                    read_word = {8'h00, bw_group[slot], bw_partition[slot]};
            OFF_BANDWIDTH_CONTROL:
                if (in_range && ctl_present)
                    read_word = {enable_reg[slot], capture_source_select[slot],
                                 clear_after_capture[slot], overflow_flag[slot],
                                 overflow_irq_enable[slot], overflow_hold[slot],
                                 4'h0, value_shift_enable[slot], 1'b0,
                                 group_filter_enable[slot], partition_filter_enable[slot],
                                 8'h00, MONITOR_TYPE_BANDWIDTH};
            OFF_BANDWIDTH_COUNTER:
                if (in_range)
                    read_word = 32'(scaled);
            OFF_BANDWIDTH_CAPTURE:
                if (in_range)
                    read_word = 32'(scaled_copy);
            default: read_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc_ack <= 1'b0;
            acc_rdata <= 32'h0000_0000;
        end
        else
        begin
            acc_ack <= acc_req;
            acc_rdata <= (acc_req && !acc_write) ? read_word : 32'h0000_0000;
        end
    end

    // Level interrupt, held while any enabled flag stays set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            overflow_irq <= 1'b0;
        else
            overflow_irq <= HAS_IRQ && |(overflow_flag & overflow_irq_enable);
    end
endmodule

// ==== bandwidth_monitor_control_monitor.sv ====
// Port-level assertion checker for the bandwidth monitor control block
`timescale 1ns/10ps
module bandwidth_monitor_control_monitor
    import bw_monitor_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Feature page access
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic [bw_monitor_pkg::ADDR_W-1:0] acc_addr,
    input wire logic [31:0] acc_rdata,
    input wire logic acc_ack,
    // Transfers and interrupt
    input wire logic xfer_valid,
    input wire logic overflow_irq
);
    // ********************
    // Helpers
    // ********************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic mapped;
    logic sw_wr;
    assign mapped = acc_addr inside {OFF_INSTANCE_SELECT, OFF_CACHE_USAGE_FILTER,
        OFF_BANDWIDTH_FILTER, OFF_BANDWIDTH_CONTROL, OFF_BANDWIDTH_COUNTER,
        OFF_BANDWIDTH_CAPTURE, OFF_SOFTWARE_CAPTURE};
    assign sw_wr = acc_req && acc_write;
    sequence read_ctl;
        acc_req && !acc_write && acc_addr == OFF_BANDWIDTH_CONTROL;
    endsequence
    sequence read_unmapped;
        acc_req && !acc_write && !mapped;
    endsequence
    // ********************
    // Assertions
    // ********************
    ack_follows_req_a: assert property (acc_req |=> acc_ack)
        else $error("ack missing after request");
    ack_only_req_a: assert property (!acc_req |=> !acc_ack)
        else $error("ack without request");
    rdata_idle_zero_a: assert property (!acc_ack |-> acc_rdata == 32'h0)
        else $error("read data not zero outside ack");
    reserved_bits_zero_a: assert property (read_ctl |=> acc_rdata[23:20] == 4'h0
        && acc_rdata[18] == 1'b0 && acc_rdata[15:8] == 8'h0)
        else $error("reserved control bits not zero");
    type_code_a: assert property (read_ctl |=> acc_rdata == 32'h0
        || acc_rdata[7:0] == MONITOR_TYPE_BANDWIDTH) else $error("wrong type code");
    unmapped_zero_a: assert property (read_unmapped |=> acc_rdata == 32'h0)
        else $error("unmapped read not zero");
    irq_cause_a: assert property ($rose(overflow_irq) |-> $past(xfer_valid)
        || $past(xfer_valid, 2) || $past(xfer_valid, 3) || $past(sw_wr) || $past(sw_wr, 2))
        else $error("interrupt rose without cause");
    irq_drop_a: assert property ($fell(overflow_irq) |-> $past(sw_wr) || $past(sw_wr, 2))
        else $error("interrupt fell without software write");
endmodule

bind bandwidth_monitor_control bandwidth_monitor_control_monitor u_monitor (
    .clk(clk),
    .rst(rst),
    .acc_req(acc_req),
    .acc_write(acc_write),
    .acc_addr(acc_addr),
    .acc_rdata(acc_rdata),
    .acc_ack(acc_ack),
    .xfer_valid(xfer_valid),
    .overflow_irq(overflow_irq)
);

// ==== bandwidth_monitor_control_tb.sv ====
// Self-checking testbench for the bandwidth monitor control block
`timescale 1ns/10ps
module bandwidth_monitor_control_tb;
    import bw_monitor_pkg::*;
    // ********************
    // Signals
    // ********************
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic acc_req = 1'h0;
    logic acc_write = 1'h0;
    logic acc_nonsecure = 1'h0;
    logic [ADDR_W-1:0] acc_addr = 12'h0;
    logic [31:0] acc_wdata = 32'h0;
    logic [31:0] acc_rdata;
    logic acc_ack;
    logic xfer_valid = 1'h0;
    logic xfer_nonsecure = 1'h0;
    logic [PARTITION_W-1:0] partition_label = 16'h0;
    logic [GROUP_W-1:0] perf_group_label = 8'h0;
    logic [7:0] xfer_bytes = 8'h0;
    logic [EXT_EVENTS-1:0] ext_capture = 6'h0;
    logic overflow_irq;
    logic [31:0] rd;
    logic [31:0] rd_lite;
    logic [31:0] rd_absent;
    logic [31:0] lite_rdata;
    logic [31:0] absent_rdata;
    logic lite_irq;
    int n_errors = 0;
    int samples_checked = 0;
    localparam logic [11:0] CTL = OFF_BANDWIDTH_CONTROL;
    localparam logic [11:0] CNT = OFF_BANDWIDTH_COUNTER;
    localparam logic [11:0] CAP = OFF_BANDWIDTH_CAPTURE;

    always #10 clk = ~clk;

    // Narrow counter so overflow is reached in a few transfers
    bandwidth_monitor_control #(.COUNT_W(8)) u_dut (
        .clk(clk),
        .rst(rst),
        .acc_req(acc_req),
        .acc_write(acc_write),
        .acc_nonsecure(acc_nonsecure),
        .acc_addr(acc_addr),
        .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata),
        .acc_ack(acc_ack),
        .xfer_valid(xfer_valid),
        .xfer_nonsecure(xfer_nonsecure),
        .partition_label(partition_label),
        .perf_group_label(perf_group_label),
        .xfer_bytes(xfer_bytes),
        .ext_capture(ext_capture),
        .overflow_irq(overflow_irq)
    );

    // Reduced builds: one without capture, overflow or interrupt, one without the monitors
    bandwidth_monitor_control #(.COUNT_W(8), .HAS_CAPTURE(1'b0), .HAS_OVERFLOW(1'b0),
        .HAS_IRQ(1'b0)) u_lite (
        .clk(clk), .rst(rst), .acc_req(acc_req), .acc_write(acc_write),
        .acc_nonsecure(acc_nonsecure), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_rdata(lite_rdata), .acc_ack(), .xfer_valid(xfer_valid),
        .xfer_nonsecure(xfer_nonsecure), .partition_label(partition_label),
        .perf_group_label(perf_group_label), .xfer_bytes(xfer_bytes),
        .ext_capture(ext_capture), .overflow_irq(lite_irq)
    );
    bandwidth_monitor_control #(.COUNT_W(8), .HAS_BANDWIDTH_MON(1'b0)) u_absent (
        .clk(clk), .rst(rst), .acc_req(acc_req), .acc_write(acc_write),
        .acc_nonsecure(acc_nonsecure), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_rdata(absent_rdata), .acc_ack(), .xfer_valid(xfer_valid),
        .xfer_nonsecure(xfer_nonsecure), .partition_label(partition_label),
        .perf_group_label(perf_group_label), .xfer_bytes(xfer_bytes),
        .ext_capture(ext_capture), .overflow_irq()
    );

    // ********************
    // Tasks
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic wr, input logic ns, input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        acc_req = 1'h1;
        acc_write = wr;
        acc_nonsecure = ns;
        acc_addr = a;
        acc_wdata = d;
        @(negedge clk);
        acc_req = 1'h0;
        rd = acc_rdata;
        rd_lite = lite_rdata;
        rd_absent = absent_rdata;
        chk({31'h0, acc_ack}, 32'h1);
    endtask

    task automatic rdchk(input logic ns, input logic [11:0] a, input logic [31:0] exp);
        acc(1'h0, ns, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic xfer(input logic ns, input logic [15:0] p, input logic [7:0] g,
        input logic [7:0] b);
        @(negedge clk);
        xfer_valid = 1'h1;
        xfer_nonsecure = ns;
        partition_label = p;
        perf_group_label = g;
        xfer_bytes = b;
        @(negedge clk);
        xfer_valid = 1'h0;
    endtask

    task automatic pulse(input logic [5:0] e);
        @(negedge clk);
        ext_capture = e;
        @(negedge clk);
        ext_capture = 6'h0;
    endtask

    task automatic end_sim();
        $display("Checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ********************
    // Tests
    // ********************
    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        rdchk(1'h0, CTL, 32'h0000_0042);
        rdchk(1'h0, 12'h8F0, 32'h0);
        acc(1'h1, 1'h0, CTL, 32'hFBFF_FFFF);
        rdchk(1'h0, CTL, 32'hFB0B_0042);
        chk(rd_lite, 32'h800B_0042);
        chk(rd_absent, 32'h0);
        rdchk(1'h1, CTL, 32'h0000_0042);
        acc(1'h1, 1'h0, OFF_INSTANCE_SELECT, 32'h1);
        rdchk(1'h0, CTL, 32'h0000_0042);
        acc(1'h1, 1'h0, OFF_INSTANCE_SELECT, 32'h0);
        rdchk(1'h0, CTL, 32'hFB0B_0042);
        acc(1'h1, 1'h0, OFF_CACHE_USAGE_FILTER, 32'hFFFF_FFFF);
        rdchk(1'h0, OFF_CACHE_USAGE_FILTER, 32'h00FF_FFFF);
        rdchk(1'h1, OFF_CACHE_USAGE_FILTER, 32'h0);
        // Filter hits and misses, including the other security state
        acc(1'h1, 1'h0, OFF_BANDWIDTH_FILTER, 32'h005A_1234);
        acc(1'h1, 1'h0, CTL, 32'h8001_0000);
        xfer(1'h0, 16'h1234, 8'h00, 8'h30);
        xfer(1'h0, 16'h1235, 8'h5A, 8'h20);
        xfer(1'h1, 16'h1234, 8'h5A, 8'h40);
        rdchk(1'h0, CNT, 32'h30);
        acc(1'h1, 1'h0, CTL, 32'h8002_0000);
        xfer(1'h0, 16'h9999, 8'h5A, 8'h20);
        xfer(1'h0, 16'h1234, 8'h5B, 8'h10);
        rdchk(1'h0, CNT, 32'h50);
        acc(1'h1, 1'h0, CTL, 32'h0008_0000);
        xfer(1'h0, 16'h1234, 8'h5A, 8'h40);
        rdchk(1'h0, CNT, 32'h05);
        // Capture with clear from external event one
        acc(1'h1, 1'h0, CTL, 32'h9800_0000);
        pulse(6'h01);
        rdchk(1'h0, CAP, 32'h50);
        rdchk(1'h0, CNT, 32'h0);
        xfer(1'h0, 16'h0, 8'h0, 8'h11);
        for (int c = 0; c < 7; c++)
        begin
            if (c != 1)
            begin
                acc(1'h1, 1'h0, CTL, {1'h1, 3'(c), 28'h0});
                pulse(c == 0 ? 6'h3F : 6'h3E);
                rdchk(1'h0, CAP, 32'h50);
            end
        end
        acc(1'h1, 1'h0, CTL, 32'hF000_0000);
        acc(1'h1, 1'h1, OFF_SOFTWARE_CAPTURE, 32'h0);
        rdchk(1'h0, CAP, 32'h50);
        acc(1'h1, 1'h0, OFF_SOFTWARE_CAPTURE, 32'h0);
        rdchk(1'h0, CAP, 32'h11);
        rdchk(1'h0, CNT, 32'h11);
        // Overflow wrap, flag, interrupt and software clear
        acc(1'h1, 1'h0, CTL, 32'h8200_0000);
        xfer(1'h0, 16'h0, 8'h0, 8'hF0);
        repeat (3) @(negedge clk);
        chk({31'h0, overflow_irq}, 32'h1);
        chk({31'h0, lite_irq}, 32'h0);
        rdchk(1'h0, CTL, 32'h8600_0042);
        chk(rd_lite, 32'h8000_0042);
        rdchk(1'h0, CNT, 32'h01);
        acc(1'h1, 1'h0, CTL, 32'h8200_0000);
        repeat (2) @(negedge clk);
        chk({31'h0, overflow_irq}, 32'h0);
        rdchk(1'h0, CTL, 32'h8200_0042);
        // Hold on overflow with the interrupt masked
        acc(1'h1, 1'h0, CTL, 32'h8100_0000);
        xfer(1'h0, 16'h0, 8'h0, 8'hFF);
        repeat (2) @(negedge clk);
        xfer(1'h0, 16'h0, 8'h0, 8'h05);
        repeat (3) @(negedge clk);
        chk({31'h0, overflow_irq}, 32'h0);
        rdchk(1'h0, CNT, 32'h0);
        rdchk(1'h0, CTL, 32'h8500_0042);
        // Second reset in mid-run
        @(negedge clk);
        rst = 1'h1;
        @(negedge clk);
        rst = 1'h0;
        rdchk(1'h0, CTL, 32'h0000_0042);
        rdchk(1'h0, CNT, 32'h0);
        end_sim();
    end

    // Run needs under two hundred cycles; cut a hang well beyond that
    initial
    begin
        #100000;
        n_errors++;
        end_sim();
    end
endmodule
